/* hw/ep_flags_defs.svh */
`ifndef EP_FLAGS_DEFS_SVH
`define EP_FLAGS_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_NRDY 12'h01c
`define IDX_EMPOVR 12'h01e
`define IDX_REQ 12'h020
`define IDX_VALUE 12'h022
`define IDX_INDEX 12'h024
`define IDX_LENGTH 12'h026
`define IDX_EPCFG 12'h030
`define IDX_CTRL 12'h032
`define IDX_ISTAT 12'h034
`define IDX_IMASK 12'h035
`define ADDR_OF(idx) ((idx) * 12'h004)

// Field layout
`define EP_COUNT 6
`define EP_MSB 5
`define CFG_ISO_LSB 0
`define CFG_IN_LSB 8
`define CTRL_DONE_BIT 0
`define CTRL_NODATA_BIT 1
`define IST_NRDY_BIT 0
`define IST_EMP_BIT 1
`define IST_STAGE_BIT 2
`define REQ_DIR_BIT 7

// Reset values
`define RST_FLAGS 6'h00
`define RST_SETUP 64'h0000_0000_0000_0000
`define RST_CFG 12'h000
`define RST_IRQ3 3'h0

`endif

/* hw/ep_flags_pkg.sv */
package ep_flags_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_DATA = 2'b10,
    ST_STATUS = 2'b11
  } stage_e;

  typedef logic [5:0] ep_mask_t;

  typedef struct packed {
    ep_mask_t nrdy;
    ep_mask_t empovr;
    logic [63:0] setup;
    logic [2:0] byte_cnt;
    ep_mask_t cfg_iso;
    ep_mask_t cfg_in;
    stage_e stage;
    logic [2:0] istat;
    logic [2:0] imask;
    logic irq;
    logic nak;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;
endpackage

/* hw/endpoint_buffer_status_flags.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ep_flags_defs.svh"
// Notes on behaviour
// - Not-ready token with non-NAK response sets flag
// - Non-isochronous not-ready endpoint answers NAK
// - Isochronous never NAKs; overrun/underrun sets flag
// - Isochronous OUT receive error sets flag
// - Not-ready flags: write 0 clears, 1 keeps
// - Flag bit n belongs to endpoint n
// - IN endpoint fully transmitted sets empty flag
// - Empty flag marks drain or endpoint-zero completion
// - OUT packet over max size sets flag
// - Empty/oversize flags: write 0 clears, 1 keeps
// - Control stage changes raise an interrupt
// - Setup packet bytes land in four request registers
// - After request, go to data or status stage
// - Request register holds code high, type low
module endpoint_buffer_status_flags
  import ep_flags_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic token_valid,
  input wire logic [2:0] token_ep,
  input wire logic token_in,
  input wire logic [5:0] buf_ready,
  input wire logic [5:0] resp_nak,
  input wire logic txn_end,
  input wire logic [2:0] txn_ep,
  input wire logic rx_error,
  input wire logic in_drained,
  input wire logic [2:0] drained_ep,
  input wire logic rx_oversize,
  input wire logic [2:0] oversize_ep,
  input wire logic setup_byte_valid,
  input wire logic [7:0] setup_byte,
  input wire logic setup_done,
  output logic handshake_nak,
  output logic [1:0] control_stage,
  output logic irq
);

  state_s s_q;
  state_s s_d;

  // APB phase decode
  logic access;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_word;
  logic rd_hit;
  assign access = psel && penable;
  assign wr_take = access && s_q.pready && pwrite;
  assign rd_take = access && s_q.pready && !pwrite;

  // One-hot endpoint decode of each event
  ep_mask_t tok_oh;
  ep_mask_t txn_oh;
  ep_mask_t drn_oh;
  ep_mask_t ovs_oh;
  always_comb begin
    tok_oh = '0;
    txn_oh = '0;
    drn_oh = '0;
    ovs_oh = '0;
    for (int i = 0; i < `EP_COUNT; i++) begin
      tok_oh[i] = token_valid && (token_ep == 3'(i));
      txn_oh[i] = txn_end && (txn_ep == 3'(i));
      drn_oh[i] = in_drained && (drained_ep == 3'(i));
      ovs_oh[i] = rx_oversize && (oversize_ep == 3'(i));
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `ADDR_OF(`IDX_NRDY): rd_word = {26'h0, s_q.nrdy};
      `ADDR_OF(`IDX_EMPOVR): rd_word = {26'h0, s_q.empovr};
      `ADDR_OF(`IDX_REQ): rd_word = {16'h0, s_q.setup[15:0]};
      `ADDR_OF(`IDX_VALUE): rd_word = {16'h0, s_q.setup[31:16]};
      `ADDR_OF(`IDX_INDEX): rd_word = {16'h0, s_q.setup[47:32]};
      `ADDR_OF(`IDX_LENGTH): rd_word = {16'h0, s_q.setup[63:48]};
      `ADDR_OF(`IDX_EPCFG): rd_word = {18'h0, s_q.cfg_in, 2'h0, s_q.cfg_iso};
      `ADDR_OF(`IDX_CTRL): rd_word = {30'h0, s_q.stage};
      `ADDR_OF(`IDX_ISTAT): rd_word = {29'h0, s_q.istat};
      `ADDR_OF(`IDX_IMASK): rd_word = {29'h0, s_q.imask};
      default: rd_hit = 1'b0;
    endcase
  end

  // Next-state logic
  ep_mask_t nrdy_set;
  ep_mask_t emp_set;
  logic stage_chg;
  logic nak_now;
  always_comb begin
    s_d = s_q;
    nrdy_set = '0;
    emp_set = '0;
    stage_chg = 1'b0;
    nak_now = 1'b0;

    // Token end: not-ready detection per endpoint
    for (int i = 0; i < `EP_COUNT; i++) begin
      if (tok_oh[i]) begin
        if (!buf_ready[i]) begin
          if (s_q.cfg_iso[i]) begin
            nrdy_set[i] = 1'b1;
          end else begin
            nak_now = 1'b1;
            if (!resp_nak[i]) begin
              nrdy_set[i] = 1'b1;
            end
          end
        end
      end
      // Isochronous OUT receive error at transaction end
      if (txn_oh[i] && rx_error && s_q.cfg_iso[i] && !s_q.cfg_in[i]) begin
        nrdy_set[i] = 1'b1;
      end
      // Buffer drained on IN side; endpoint zero always counts
      if (drn_oh[i] && (s_q.cfg_in[i] || i == 0)) begin
        emp_set[i] = 1'b1;
      end
      // Oversize packet on OUT side
      if (ovs_oh[i] && (!s_q.cfg_in[i] || i == 0)) begin
        emp_set[i] = 1'b1;
      end
    end

    // Software writes: zero clears, one keeps, hardware set wins
    if (wr_take && paddr == `ADDR_OF(`IDX_NRDY)) begin
      s_d.nrdy = s_q.nrdy & pwdata[`EP_MSB:0];
    end
    if (wr_take && paddr == `ADDR_OF(`IDX_EMPOVR)) begin
      s_d.empovr = s_q.empovr & pwdata[`EP_MSB:0];
    end
    s_d.nrdy = s_d.nrdy | nrdy_set;
    s_d.empovr = s_d.empovr | emp_set;

    // Endpoint configuration and interrupt mask
    if (wr_take && paddr == `ADDR_OF(`IDX_EPCFG)) begin
      s_d.cfg_iso = pwdata[`CFG_ISO_LSB +: `EP_COUNT];
      s_d.cfg_in = pwdata[`CFG_IN_LSB +: `EP_COUNT];
    end
    if (wr_take && paddr == `ADDR_OF(`IDX_IMASK)) begin
      s_d.imask = pwdata[2:0];
    end

    // Setup bytes fill the request registers in arrival order
    if (setup_byte_valid) begin
      s_d.setup[{s_q.byte_cnt, 3'b000} +: 8] = setup_byte;
      s_d.byte_cnt = s_q.byte_cnt + 3'h1;
    end

    // Control transfer stage tracking
    unique case (s_q.stage)
      ST_IDLE: begin
      end
      ST_SETUP: begin
        if (wr_take && paddr == `ADDR_OF(`IDX_CTRL) && pwdata[`CTRL_DONE_BIT]) begin
          s_d.stage = pwdata[`CTRL_NODATA_BIT] ? ST_STATUS : ST_DATA;
          stage_chg = 1'b1;
        end
      end
      ST_DATA: begin
        if (tok_oh[0] && (token_in != s_q.setup[`REQ_DIR_BIT])) begin
          s_d.stage = ST_STATUS;
          stage_chg = 1'b1;
        end
      end
      ST_STATUS: begin
        if (txn_oh[0] && !rx_error) begin
          s_d.stage = ST_IDLE;
          stage_chg = 1'b1;
        end
      end
    endcase
    if (setup_done) begin
      s_d.stage = ST_SETUP;
      s_d.byte_cnt = 3'h0;
      stage_chg = 1'b1;
    end

    // Sticky interrupt status: read clears, new event wins
    if (rd_take && paddr == `ADDR_OF(`IDX_ISTAT)) begin
      s_d.istat = `RST_IRQ3;
    end
    if (|nrdy_set) begin
      s_d.istat[`IST_NRDY_BIT] = 1'b1;
    end
    if (|emp_set) begin
      s_d.istat[`IST_EMP_BIT] = 1'b1;
    end
    if (stage_chg) begin
      s_d.istat[`IST_STAGE_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.istat & s_d.imask);
    s_d.nak = nak_now;

    // APB answer after one wait cycle
    s_d.pready = access && !s_q.pready;
    s_d.pslverr = access && !s_q.pready && !rd_hit;
    if (access && !s_q.pready) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.nrdy <= `RST_FLAGS;
      s_q.empovr <= `RST_FLAGS;
      s_q.setup <= `RST_SETUP;
      s_q.byte_cnt <= 3'h0;
      s_q.cfg_iso <= `RST_FLAGS;
      s_q.cfg_in <= `RST_FLAGS;
      s_q.stage <= ST_IDLE;
      s_q.istat <= `RST_IRQ3;
      s_q.imask <= `RST_IRQ3;
      s_q.irq <= 1'b0;
      s_q.nak <= 1'b0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign handshake_nak = s_q.nak;
  assign control_stage = s_q.stage;
  assign irq = s_q.irq;

  // Not-ready flag checks
  a_nrdy_on_token: assert property (@(posedge pclk) disable iff (!presetn)
    (token_valid && token_ep < 3'd6 && !buf_ready[token_ep] && !resp_nak[token_ep])
    |=> s_q.nrdy[$past(token_ep)])
    else $error("not-ready flag missed on token");
  a_nak_non_iso: assert property (@(posedge pclk) disable iff (!presetn)
    (token_valid && token_ep < 3'd6 && !buf_ready[token_ep] && !s_q.cfg_iso[token_ep])
    |=> handshake_nak)
    else $error("no NAK for not-ready endpoint");
  a_iso_no_nak: assert property (@(posedge pclk) disable iff (!presetn)
    (token_valid && token_ep < 3'd6 && s_q.cfg_iso[token_ep])
    |=> !handshake_nak)
    else $error("isochronous endpoint answered NAK");
  a_iso_underrun: assert property (@(posedge pclk) disable iff (!presetn)
    (token_valid && token_ep < 3'd6 && s_q.cfg_iso[token_ep] && !buf_ready[token_ep])
    |=> s_q.nrdy[$past(token_ep)]) else $error("isochronous underrun not flagged");
  a_iso_rx_err: assert property (@(posedge pclk) disable iff (!presetn)
    (txn_end && txn_ep < 3'd6 && rx_error && s_q.cfg_iso[txn_ep] && !s_q.cfg_in[txn_ep])
    |=> s_q.nrdy[$past(txn_ep)]) else $error("isochronous receive error not flagged");
  a_nrdy_w0c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == `ADDR_OF(`IDX_NRDY) && !token_valid && !txn_end)
    |=> s_q.nrdy == ($past(s_q.nrdy) & $past(pwdata[5:0])))
    else $error("not-ready flag write mismatch");
  // Empty/oversize flag checks
  a_empovr_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == `ADDR_OF(`IDX_EMPOVR))
    |=> (s_q.empovr & $past(s_q.empovr & pwdata[5:0])) == $past(s_q.empovr & pwdata[5:0]))
    else $error("empty flag lost on write of one");
  a_empovr_w0c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == `ADDR_OF(`IDX_EMPOVR) && !in_drained && !rx_oversize)
    |=> s_q.empovr == ($past(s_q.empovr) & $past(pwdata[5:0])))
    else $error("empty flag write mismatch");
  a_in_drain: assert property (@(posedge pclk) disable iff (!presetn)
    (in_drained && drained_ep < 3'd6 && s_q.cfg_in[drained_ep])
    |=> s_q.empovr[$past(drained_ep)]) else $error("drained IN buffer not flagged");
  a_drain_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (in_drained && drained_ep == 3'd0) |=> s_q.empovr[0])
    else $error("endpoint zero completion not flagged");
  a_out_oversize: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_oversize && oversize_ep < 3'd6 && !s_q.cfg_in[oversize_ep])
    |=> s_q.empovr[$past(oversize_ep)]) else $error("oversize OUT packet not flagged");
  // Control stage and request checks
  a_stage_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.stage != $past(s_q.stage)) |-> s_q.istat[`IST_STAGE_BIT])
    else $error("stage change without interrupt status");
  a_setup_next: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.stage == ST_SETUP && wr_take && paddr == `ADDR_OF(`IDX_CTRL) && pwdata[0]
      && !setup_done) |=> (s_q.stage == ST_STATUS || s_q.stage == ST_DATA))
    else $error("request completion did not advance stage");
  a_data_to_status: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.stage == ST_DATA && token_valid && token_ep == 3'd0 && !setup_done
      && token_in != s_q.setup[`REQ_DIR_BIT]) |=> s_q.stage == ST_STATUS)
    else $error("data stage did not end on opposite token");
  a_status_end: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.stage == ST_STATUS && txn_end && txn_ep == 3'd0 && !rx_error && !setup_done)
    |=> s_q.stage == ST_IDLE) else $error("status stage did not complete");
  a_setup_done: assert property (@(posedge pclk) disable iff (!presetn)
    setup_done |=> (s_q.stage == ST_SETUP && s_q.byte_cnt == 3'h0))
    else $error("setup end did not restart capture");
  a_req_byte0: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_byte_valid && s_q.byte_cnt == 3'd0) |=> s_q.setup[7:0] == $past(setup_byte))
    else $error("first setup byte not captured");
  a_req_code_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_byte_valid && s_q.byte_cnt == 3'd1) |=> s_q.setup[15:8] == $past(setup_byte))
    else $error("request code not in high byte");
  // Bus and interrupt checks
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && (paddr == `ADDR_OF(`IDX_NRDY) || paddr == `ADDR_OF(`IDX_EMPOVR))
      && !pwrite) |-> prdata[31:6] == 26'h0)
    else $error("reserved flag bits not zero");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready) |=> pready)
    else $error("APB answer late");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("APB answer held too long");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(s_q.istat & s_q.imask))
    else $error("interrupt level mismatch");

  // Scenario covers
  c_full_ctrl: cover property (@(posedge pclk) disable iff (!presetn)
    s_q.stage == ST_STATUS ##[1:1000] s_q.stage == ST_IDLE);
  c_data_stage: cover property (@(posedge pclk) disable iff (!presetn)
    s_q.stage == ST_DATA ##1 s_q.stage == ST_STATUS);
  c_nak_sent: cover property (@(posedge pclk) disable iff (!presetn) handshake_nak);
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_oversize: cover property (@(posedge pclk) disable iff (!presetn)
    rx_oversize ##1 (|s_q.empovr));

endmodule

/* tb/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic pclk,
  output logic token_valid,
  output logic [2:0] token_ep,
  output logic token_in,
  output logic txn_end,
  output logic [2:0] txn_ep,
  output logic rx_error,
  output logic in_drained,
  output logic [2:0] drained_ep,
  output logic rx_oversize,
  output logic [2:0] oversize_ep,
  output logic setup_byte_valid,
  output logic [7:0] setup_byte,
  output logic setup_done
);
  // Quiet bus at time zero
  initial begin
    {token_valid, txn_end, in_drained, rx_oversize, setup_byte_valid, setup_done} = '0;
    {token_ep, token_in, txn_ep, rx_error, drained_ep, oversize_ep, setup_byte} = '0;
  end

  // One event: 0 token, 1 transaction end, 2 drained, 3 oversize
  task pulse(input int k, input logic [2:0] e, input logic f);
    token_valid <= (k == 0);
    txn_end <= (k == 1);
    in_drained <= (k == 2);
    rx_oversize <= (k == 3);
    {token_ep, txn_ep, drained_ep, oversize_ep} <= {4{e}};
    {token_in, rx_error} <= {f, f};
    @(posedge pclk);
    {token_valid, txn_end, in_drained, rx_oversize} <= 4'h0;
    {token_ep, txn_ep, drained_ep, oversize_ep} <= {4{~e}};
    {token_in, rx_error} <= {~f, ~f};
    @(posedge pclk);
  endtask

  // Eight setup bytes in order, then end of transaction
  task setup(input logic [63:0] b);
    for (int n = 0; n < 8; n++) begin
      setup_byte_valid <= 1'b1;
      setup_byte <= b[8*n +: 8];
      @(posedge pclk);
    end
    setup_byte_valid <= 1'b0;
    setup_byte <= ~b[63:56];
    setup_done <= 1'b1;
    @(posedge pclk);
    setup_done <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

/* tb/endpoint_buffer_status_flags_test.sv */
`timescale 1ns/1ps
`include "ep_flags_defs.svh"
module endpoint_buffer_status_flags_test
  import ep_flags_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, handshake_nak, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, w;
  logic [5:0] buf_ready, resp_nak, nrdy;
  logic [1:0] control_stage;
  logic token_valid, token_in, txn_end, rx_error, in_drained, rx_oversize, hit;
  logic setup_byte_valid, setup_done;
  logic [2:0] token_ep, txn_ep, drained_ep, oversize_ep;
  logic [7:0] setup_byte;
  logic [63:0] pkt;
  logic [32:0] exp_q[$];
  logic [32:0] nak_q[$];
  int num_errors = 0;
  int tests_run = 0;

  endpoint_buffer_status_flags endpoint_buffer_status_flags_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .token_valid, .token_ep,
    .token_in, .buf_ready, .resp_nak, .txn_end, .txn_ep, .rx_error, .in_drained, .drained_ep,
    .rx_oversize, .oversize_ep, .setup_byte_valid, .setup_byte, .setup_done, .handshake_nak,
    .control_stage, .irq);
  host_model host_model_i (.pclk, .token_valid, .token_ep, .token_in, .txn_end, .txn_ep,
    .rx_error, .in_drained, .drained_ep, .rx_oversize, .oversize_ep, .setup_byte_valid,
    .setup_byte, .setup_done);

  task chk(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task finish_test();
    if (exp_q.size() != 0 || nak_q.size() != 0) num_errors++;
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // APB transfer; a read notes its expected answer first
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Watcher: read answers and handshake pulses against oldest notes
  always @(posedge pclk) begin
    if (pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h0);
    if (handshake_nak === 1'b1)
      chk(33'h1, nak_q.size() ? nak_q.pop_front() : 33'h0);
  end

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Watchdog
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, resp_nak, nrdy} = '0;
    buf_ready = 6'h3f;
    w = $urandom(84);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped place
    apb(0, `ADDR_OF(`IDX_NRDY), 0, 33'h0);
    apb(0, `ADDR_OF(`IDX_EMPOVR), 0, 33'h0);
    apb(0, 12'h004, 0, 33'h1_0000_0000);
    apb(1, `ADDR_OF(`IDX_IMASK), 32'h1, 0);
    apb(1, `ADDR_OF(`IDX_EPCFG), 32'h0608, 0);
    apb(0, `ADDR_OF(`IDX_EPCFG), 0, 33'h0608);
    // Random tokens on every endpoint number, then clear by random pattern
    repeat (3) begin
      hit = 1'b0;
      for (int e = 0; e < 8; e++) begin
        w = $urandom;
        buf_ready <= w[5:0];
        resp_nak <= w[11:6];
        if (e < 6 && !w[e]) begin
          if (e == 3 || !w[6+e]) begin
            nrdy[e] = 1'b1;
            hit = 1'b1;
          end
          if (e != 3) nak_q.push_back(33'h1);
        end
        host_model_i.pulse(0, e[2:0], w[12]);
      end
      apb(0, `ADDR_OF(`IDX_NRDY), 0, {27'h0, nrdy});
      chk({32'h0, irq}, {32'h0, hit});
      apb(0, `ADDR_OF(`IDX_ISTAT), 0, {32'h0, hit});
      chk({32'h0, irq}, 33'h0);
      w = $urandom;
      apb(1, `ADDR_OF(`IDX_NRDY), w, 0);
      nrdy = nrdy & w[5:0];
      apb(0, `ADDR_OF(`IDX_NRDY), 0, {27'h0, nrdy});
    end
    // Receive error, drains and oversize by direction
    buf_ready <= 6'h3f;
    apb(1, `ADDR_OF(`IDX_NRDY), 32'h0, 0);
    host_model_i.pulse(1, 3'd3, 1'b1);
    host_model_i.pulse(1, 3'd1, 1'b1);
    host_model_i.pulse(2, 3'd1, 1'b0);
    host_model_i.pulse(2, 3'd4, 1'b0);
    host_model_i.pulse(3, 3'd4, 1'b0);
    host_model_i.pulse(3, 3'd2, 1'b0);
    host_model_i.pulse(2, 3'd0, 1'b0);
    apb(0, `ADDR_OF(`IDX_NRDY), 0, 33'h08);
    apb(0, `ADDR_OF(`IDX_EMPOVR), 0, 33'h13);
    apb(1, `ADDR_OF(`IDX_EMPOVR), 32'hffff_ffee, 0);
    apb(0, `ADDR_OF(`IDX_EMPOVR), 0, 33'h02);
    apb(1, `ADDR_OF(`IDX_IMASK), 32'h4, 0);
    apb(0, `ADDR_OF(`IDX_IMASK), 0, 33'h4);
    apb(0, `ADDR_OF(`IDX_ISTAT), 0, 33'h3);
    // Setup capture and stage walk, without and with a data stage
    for (int k = 0; k < 2; k++) begin
      pkt = {$urandom, $urandom};
      host_model_i.setup(pkt);
      chk({31'h0, control_stage}, {31'h0, ST_SETUP});
      chk({32'h0, irq}, 33'h1);
      apb(0, `ADDR_OF(`IDX_REQ), 0, {17'h0, pkt[15:0]});
      apb(0, `ADDR_OF(`IDX_VALUE), 0, {17'h0, pkt[31:16]});
      apb(0, `ADDR_OF(`IDX_INDEX), 0, {17'h0, pkt[47:32]});
      apb(0, `ADDR_OF(`IDX_LENGTH), 0, {17'h0, pkt[63:48]});
      apb(1, `ADDR_OF(`IDX_CTRL), k ? 32'h1 : 32'h3, 0);
      chk({31'h0, control_stage}, {31'h0, k ? ST_DATA : ST_STATUS});
      apb(0, `ADDR_OF(`IDX_CTRL), 0, {31'h0, k ? ST_DATA : ST_STATUS});
      if (k) host_model_i.pulse(0, 3'd0, ~pkt[7]);
      chk({31'h0, control_stage}, {31'h0, ST_STATUS});
      host_model_i.pulse(1, 3'd0, 1'b1);
      chk({31'h0, control_stage}, {31'h0, ST_STATUS});
      host_model_i.pulse(1, 3'd0, 1'b0);
      chk({31'h0, control_stage}, {31'h0, ST_IDLE});
      apb(0, `ADDR_OF(`IDX_ISTAT), 0, 33'h4);
      chk({32'h0, irq}, 33'h0);
    end
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule
